// File: src/spf_pkg.sv
// Purpose: constants and types for the serial port fifo control block
// Assumes: 32-bit apb, one word per register
// Notes:   offsets are byte addresses
package spf_pkg;
    localparam logic [11:0] TXFC_OFFSET  = 12'h000;
    localparam logic [11:0] RXFC_OFFSET  = 12'h004;
    localparam logic [11:0] FSTAT_OFFSET = 12'h008;
    localparam logic [11:0] ISTAT_OFFSET = 12'h00C;
    localparam logic [11:0] IMASK_OFFSET = 12'h010;
    localparam logic [11:0] TXDATA_OFFSET = 12'h014;
    localparam logic [11:0] RXDATA_OFFSET = 12'h018;

    localparam int EN_BIT    = 0;
    localparam int FLUSH_BIT = 1;
    localparam int TM_BIT    = 2;
    localparam int TL_LSB    = 8;
    localparam int TXFL_LSB  = 8;
    localparam int RXFL_LSB  = 0;

    localparam logic [15:0] TXFC_RESET = 16'h0100;
    localparam logic [15:0] RXFC_RESET = 16'h0100;
    localparam logic [3:0]  FIFO_DEPTH = 4'h8;
    localparam int          NUM_IRQ    = 6;

    // status bits: 0 tx request, 1 rx request, 2 tx overflow,
    // 3 rx overflow, 4 tx empty, 5 rx read underflow
    localparam int IRQ_TX    = 0;
    localparam int IRQ_RX    = 1;
    localparam int IRQ_TXOVF = 2;
    localparam int IRQ_RXOVF = 3;
    localparam int IRQ_TXE   = 4;
    localparam int IRQ_RXUND = 5;

    typedef struct packed {
        logic [2:0]         tx_wptr;
        logic [2:0]         tx_rptr;
        logic [3:0]         tx_fill_level;
        logic [2:0]         rx_wptr;
        logic [2:0]         rx_rptr;
        logic [3:0]         rx_fill_level;
        logic [7:0][7:0]    tx_mem;
        logic [7:0][7:0]    rx_mem;
        logic               tx_queue_enable;
        logic               tx_transparent_select;
        logic [3:0]         tx_trigger_level;
        logic               rx_queue_enable;
        logic               rx_transparent_select;
        logic [3:0]         rx_trigger_level;
        logic [NUM_IRQ-1:0] irq_status;
        logic [NUM_IRQ-1:0] irq_mask;
        logic [NUM_IRQ-1:0] irq_lines;
        logic               irq;
        logic               tx_valid;
        logic [7:0]         tx_data;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
    } spf_state_type;
endpackage

// File: src/spf_fifo_control.sv
// Purpose: tx/rx fifo control, fill status and irq for a serial port
// Assumes: shift engine pops tx bytes and pushes rx bytes, one per cycle
// Notes:   apb slave answers one cycle after the first enable cycle
`timescale 1ns/1ps
`default_nettype none

module spf_fifo_control (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_take,
    input  wire logic        rx_push,
    input  wire logic [7:0]  rx_byte,
    output logic [5:0]       irq_lines,
    output logic             irq
);
    spf_pkg::spf_state_type st_reg;
    spf_pkg::spf_state_type st_next;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    // true for any of the seven register words
    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, spf_pkg::TXFC_OFFSET) ||
                 hit(a, spf_pkg::RXFC_OFFSET) ||
                 hit(a, spf_pkg::FSTAT_OFFSET) ||
                 hit(a, spf_pkg::ISTAT_OFFSET) ||
                 hit(a, spf_pkg::IMASK_OFFSET) ||
                 hit(a, spf_pkg::TXDATA_OFFSET) ||
                 hit(a, spf_pkg::RXDATA_OFFSET);
    endfunction

    // control readback; the flush bit always reads zero
    function automatic logic [31:0] ctl_word(input logic       en,
                                             input logic       tm,
                                             input logic [3:0] level);
        ctl_word = 32'h0000_0000;
        ctl_word[spf_pkg::EN_BIT] = en;
        ctl_word[spf_pkg::TM_BIT] = tm;
        ctl_word[spf_pkg::TL_LSB +: 4] = level;
    endfunction

    // a level of 0 or beyond depth is treated as the depth
    function automatic logic [3:0] lvl(input logic [3:0] code);
        if (code == 4'h0 || code > spf_pkg::FIFO_DEPTH) begin
            lvl = spf_pkg::FIFO_DEPTH;
        end else begin
            lvl = code;
        end
    endfunction

    logic access;
    logic wr;
    logic rd;
    logic tx_pop;
    logic tx_push;
    logic rx_wr;
    logic rx_rd;
    logic tx_flush;
    logic rx_flush;
    localparam int NUM_EV = spf_pkg::NUM_IRQ;
    logic [NUM_EV-1:0] ev;
    logic              tx_full;
    logic              rx_full;
    logic              rx_empty;
    logic              stat_rd;
    logic [NUM_EV-1:0] stat_keep;

    assign tx_full  = st_reg.tx_fill_level >= spf_pkg::FIFO_DEPTH;
    assign rx_full  = st_reg.rx_fill_level >= spf_pkg::FIFO_DEPTH;
    assign rx_empty = st_reg.rx_fill_level == 4'h0;
    assign stat_rd  = psel && penable && !st_reg.pready && !pwrite &&
                      hit(paddr, spf_pkg::ISTAT_OFFSET);

    // status bits survive unless a status read clears them
    for (genvar g = 0; g < NUM_EV; g++) begin : g_keep
        assign stat_keep[g] = st_reg.irq_status[g] && !stat_rd;
    end

    always_comb begin
        st_next  = st_reg;
        access   = psel && penable && !st_reg.pready;
        wr       = access && pwrite;
        rd       = access && !pwrite;
        ev       = '0;
        tx_flush = 1'b0;
        rx_flush = 1'b0;
        tx_push  = 1'b0;
        rx_rd    = 1'b0;
        st_next.pready  = access;
        st_next.pslverr = 1'b0;
        st_next.prdata  = st_reg.prdata;

        // register writes
        if (wr && hit(paddr, spf_pkg::TXFC_OFFSET)) begin
            st_next.tx_queue_enable = pwdata[spf_pkg::EN_BIT];
            st_next.tx_transparent_select = pwdata[spf_pkg::TM_BIT];
            st_next.tx_trigger_level = pwdata[spf_pkg::TL_LSB +: 4];
            tx_flush = pwdata[spf_pkg::FLUSH_BIT] ||
                       !pwdata[spf_pkg::EN_BIT];
        end
        if (wr && hit(paddr, spf_pkg::RXFC_OFFSET)) begin
            st_next.rx_queue_enable = pwdata[spf_pkg::EN_BIT];
            st_next.rx_transparent_select = pwdata[spf_pkg::TM_BIT];
            st_next.rx_trigger_level = pwdata[spf_pkg::TL_LSB +: 4];
            rx_flush = pwdata[spf_pkg::FLUSH_BIT] ||
                       !pwdata[spf_pkg::EN_BIT];
        end
        if (wr && hit(paddr, spf_pkg::IMASK_OFFSET)) begin
            st_next.irq_mask = pwdata[NUM_EV-1:0];
        end
        if (wr && hit(paddr, spf_pkg::TXDATA_OFFSET)) begin
            if (!tx_full) begin
                tx_push = 1'b1;
            end else begin
                ev[spf_pkg::IRQ_TXOVF] = 1'b1;
            end
        end
        if (access && !mapped(paddr)) begin
            st_next.pslverr = 1'b1;
        end

        // register reads
        if (rd) begin
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                spf_pkg::TXFC_OFFSET: begin
                    st_next.prdata = ctl_word(st_reg.tx_queue_enable,
                                              st_reg.tx_transparent_select,
                                              st_reg.tx_trigger_level);
                end
                spf_pkg::RXFC_OFFSET: begin
                    st_next.prdata = ctl_word(st_reg.rx_queue_enable,
                                              st_reg.rx_transparent_select,
                                              st_reg.rx_trigger_level);
                end
                spf_pkg::FSTAT_OFFSET: begin
                    st_next.prdata[spf_pkg::TXFL_LSB +: 4] =
                        st_reg.tx_fill_level;
                    st_next.prdata[spf_pkg::RXFL_LSB +: 4] =
                        st_reg.rx_fill_level;
                end
                spf_pkg::ISTAT_OFFSET: begin
                    st_next.prdata[NUM_EV-1:0] = st_reg.irq_status;
                end
                spf_pkg::IMASK_OFFSET: begin
                    st_next.prdata[NUM_EV-1:0] = st_reg.irq_mask;
                end
                spf_pkg::RXDATA_OFFSET: begin
                    if (!rx_empty) begin
                        st_next.prdata[7:0] = st_reg.rx_mem[st_reg.rx_rptr];
                        rx_rd = 1'b1;
                    end else begin
                        ev[spf_pkg::IRQ_RXUND] = 1'b1;
                    end
                end
                default: begin
                    st_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // tx side: pop toward the shift engine
        tx_pop = tx_take && st_reg.tx_valid && !tx_flush;
        if (tx_flush) begin
            st_next.tx_wptr = 3'h0;
            st_next.tx_rptr = 3'h0;
            st_next.tx_fill_level = 4'h0;
        end else begin
            if (tx_push) begin
                st_next.tx_mem[st_reg.tx_wptr] = pwdata[7:0];
                st_next.tx_wptr = st_reg.tx_wptr + 3'h1;
            end
            if (tx_pop) begin
                st_next.tx_rptr = st_reg.tx_rptr + 3'h1;
            end
            st_next.tx_fill_level = st_reg.tx_fill_level +
                {3'h0, tx_push} - {3'h0, tx_pop};
        end
        if (tx_pop) begin
            if ((st_reg.tx_queue_enable && st_reg.tx_transparent_select) ||
                (st_next.tx_fill_level <= lvl(st_reg.tx_trigger_level))) begin
                ev[spf_pkg::IRQ_TX] = 1'b1;
            end
            if (st_next.tx_fill_level == 4'h0) begin
                ev[spf_pkg::IRQ_TXE] = 1'b1;
            end
        end
        st_next.tx_valid = st_next.tx_fill_level != 4'h0;
        st_next.tx_data  = st_next.tx_mem[st_next.tx_rptr];

        // rx side: push from the shift engine
        rx_wr = rx_push && !rx_flush && !rx_full;
        if (rx_push && !rx_wr && !rx_flush) begin
            ev[spf_pkg::IRQ_RXOVF] = 1'b1;
        end
        if (rx_flush) begin
            st_next.rx_wptr = 3'h0;
            st_next.rx_rptr = 3'h0;
            st_next.rx_fill_level = 4'h0;
        end else begin
            if (rx_wr) begin
                st_next.rx_mem[st_reg.rx_wptr] = rx_byte;
                st_next.rx_wptr = st_reg.rx_wptr + 3'h1;
            end
            if (rx_rd) begin
                st_next.rx_rptr = st_reg.rx_rptr + 3'h1;
            end
            st_next.rx_fill_level = st_reg.rx_fill_level +
                {3'h0, rx_wr} - {3'h0, rx_rd};
        end
        if (rx_wr) begin
            if ((st_reg.rx_queue_enable && st_reg.rx_transparent_select) ||
                (st_next.rx_fill_level >= lvl(st_reg.rx_trigger_level))) begin
                ev[spf_pkg::IRQ_RX] = 1'b1;
            end
        end

        // sticky status, read clears, new event wins
        st_next.irq_status = stat_keep | ev;
        st_next.irq_lines = st_next.irq_status & st_next.irq_mask;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.tx_trigger_level <= spf_pkg::TXFC_RESET[11:8];
            st_reg.rx_trigger_level <= spf_pkg::RXFC_RESET[11:8];
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign pready    = st_reg.pready;
    assign prdata    = st_reg.prdata;
    assign pslverr   = st_reg.pslverr;
    assign tx_valid  = st_reg.tx_valid;
    assign tx_data   = st_reg.tx_data;
    assign irq_lines = st_reg.irq_lines;
    assign irq       = st_reg.irq;
endmodule

`default_nettype wire

// File: verif/spf_fifo_control_asserts.sv
// Purpose: port checks for spf_fifo_control
// Assumes: clk_en held high, one apb request at a time
// Notes:   tx count, level, mode and mask tracked from apb writes
`timescale 1ns/1ps
`default_nettype none
module spf_fifo_control_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        tx_valid,
    input wire logic        tx_take,
    input wire logic [5:0]  irq_lines,
    input wire logic        irq
);
    logic [3:0] cnt_reg;
    logic [3:0] lvl_reg;
    logic       tm_reg;
    logic       m0_reg;
    logic       wa;
    logic       wd;
    logic       pop;
    logic [3:0] lvl;
    assign wa = psel && penable && !pready && pwrite;
    assign wd = wa && paddr == spf_pkg::TXDATA_OFFSET && cnt_reg != 4'h8;
    assign pop = tx_take && tx_valid;
    assign lvl = (lvl_reg == 4'h0 || lvl_reg > 4'h8) ? 4'h8 : lvl_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {cnt_reg, lvl_reg, tm_reg, m0_reg} <= {8'h01, 2'b00};
        end else begin
            cnt_reg <= cnt_reg + 4'(wd) - 4'(pop);
            if (wa && paddr == spf_pkg::TXFC_OFFSET) begin
                lvl_reg <= pwdata[11:8];
                tm_reg <= pwdata[0] && pwdata[2];
                if (pwdata[1] || !pwdata[0]) begin
                    cnt_reg <= 4'h0;
                end
            end
            if (wa && paddr == spf_pkg::IMASK_OFFSET) begin
                m0_reg <= pwdata[0];
            end
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    apb_answer_a: assert property (access_s |=> answer_s)
        else $error("apb answer");
    bad_addr_a: assert property (
        psel && penable && !pready && paddr > 12'h018 |=> pslverr)
        else $error("no slave error");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("stray error");
    flush_zero_a: assert property (
        pready && !pwrite && paddr == 12'h000 |-> !prdata[1])
        else $error("flush bit read");
    tx_fill_a: assert property (
        pready && !pwrite && paddr == 12'h008
        |-> prdata[11:8] == $past(cnt_reg)) else $error("tx fill");
    valid_count_a: assert property (tx_valid == (cnt_reg != 4'h0))
        else $error("tx count");
    flush_empty_a: assert property (
        access_s and (pwrite && paddr == 12'h000 &&
        !(pwdata[0] && !pwdata[1]))
        |=> !tx_valid) else $error("flush");
    tx_request_a: assert property (
        pop && m0_reg && (tm_reg || cnt_reg - 4'h1 <= lvl)
        |=> ##[0:1] irq_lines[0]) else $error("tx request");
    irq_any_a: assert property (irq == (|irq_lines))
        else $error("irq line");
endmodule
bind spf_fifo_control spf_fifo_control_asserts spf_fifo_control_asserts_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_take(tx_take), .irq_lines(irq_lines), .irq(irq));
`default_nettype wire

// File: verif/spf_shift_model.sv
// Purpose: shift engine model, drains tx and feeds rx bytes
// Assumes: counts up to take_max and push_max set by the bench
// Notes:   rx_byte toggles between pushes, never holds stale data
`timescale 1ns/1ps
`default_nettype none
module spf_shift_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic [7:0] take_max,
    input  wire logic [7:0] push_max,
    output logic            tx_take,
    output logic            rx_push,
    output logic [7:0]      rx_byte,
    output logic [7:0]      n_taken,
    output logic [7:0]      n_pushed,
    output logic [7:0]      last_byte
);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {tx_take, rx_push, rx_byte, n_taken, n_pushed, last_byte} <= '0;
        end else begin
            tx_take <= tx_valid && !tx_take && n_taken < take_max;
            if (tx_take && tx_valid) begin
                n_taken <= n_taken + 8'h01;
                last_byte <= tx_data;
            end
            rx_push <= !rx_push && n_pushed < push_max;
            rx_byte <= ~rx_byte;
            if (!rx_push && n_pushed < push_max) begin
                rx_byte <= 8'hA0 + n_pushed;
                n_pushed <= n_pushed + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for spf_fifo_control
// Assumes: 40 MHz clock, apb answer after a two-cycle access
// Notes:   table rows first, then drain, level, full and rx cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
        logic        e;
    } spf_row_type;
    logic        clk_sys, rst, clk_en, psel, penable, pwrite, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        pready, pslverr, tx_valid, tx_take, rx_push, irq;
    logic [7:0]  tx_data, rx_byte, tmax, pmax, ntk, npu, lastb;
    logic [5:0]  irq_lines;
    int          fail_count = 0;
    int          cmp_count = 0;
    // trigger codes stay within one to eight
    spf_row_type rows [10] = '{
        '{12'h000, 1'b0, 32'h100, 1'b0}, '{12'h008, 1'b0, 32'h0, 1'b0},
        '{12'h010, 1'b1, 32'h3F, 1'b0}, '{12'h000, 1'b1, 32'h307, 1'b0},
        '{12'h000, 1'b0, 32'h305, 1'b0}, '{12'h014, 1'b1, 32'h11, 1'b0},
        '{12'h014, 1'b1, 32'h22, 1'b0}, '{12'h014, 1'b1, 32'h33, 1'b0},
        '{12'h008, 1'b0, 32'h300, 1'b0}, '{12'h01C, 1'b0, 32'h0, 1'b1}};
    spf_fifo_control spf_fifo_control_i (.clk_sys(clk_sys), .rst(rst),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_take(tx_take), .rx_push(rx_push), .rx_byte(rx_byte),
        .irq_lines(irq_lines), .irq(irq));
    spf_shift_model spf_shift_model_i (.clk_sys(clk_sys), .rst(rst),
        .tx_valid(tx_valid), .tx_data(tx_data), .take_max(tmax),
        .push_max(pmax), .tx_take(tx_take), .rx_push(rx_push),
        .rx_byte(rx_byte), .n_taken(ntk), .n_pushed(npu), .last_byte(lastb));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic xf(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        if (pready !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t no apb answer", $time);
        end
        rv = prdata;
        ev = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xf(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
        xf(a, 1'b0, 32'h0);
        chk(rv & m, x);
    endtask
    task automatic fill(input int n);
        for (int k = 0; k < n; k++) wr(12'h014, 32'(k));
    endtask
    task automatic run(input logic [7:0] t, input logic [7:0] p);
        @(posedge clk_sys);
        {tmax, pmax} <= {t, p};
        for (int k = 0; k < 60 && (ntk !== t || npu !== p); k++)
            @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic ck_irq(input logic x);
        @(negedge clk_sys);
        chk(32'(irq), 32'(x));
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        finish_test;
    end
    initial begin
        {rst, clk_en, psel, penable, pwrite, paddr, pwdata} = {5'b11000, 44'h0};
        {tmax, pmax} = 16'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            xf(rows[i].a, rows[i].w, rows[i].d);
            chk(32'(ev), 32'(rows[i].e));
            if (!rows[i].w && !rows[i].e) chk(rv, rows[i].d);
        end
        chk(32'($bits(irq_lines)), 32'h6);
        rd(12'h00C, 32'h3F, 32'h0);
        run(8'h3, 8'h0);
        chk(32'(lastb), 32'h33);
        rd(12'h00C, 32'h1, 32'h1);
        rd(12'h008, 32'hFFFF, 32'h0);
        ck_irq(1'b0);
        wr(12'h010, 32'h1);
        wr(12'h000, 32'h101);
        fill(4);
        run(8'h4, 8'h0);
        ck_irq(1'b0);
        wr(12'h000, 32'h105);
        run(8'h5, 8'h0);
        ck_irq(1'b1);
        rd(12'h00C, 32'h3F, 32'h1);
        wr(12'h000, 32'h104);
        rd(12'h008, 32'hFFFF, 32'h0);
        fill(3);
        run(8'h6, 8'h0);
        ck_irq(1'b0);
        wr(12'h000, 32'h103);
        rd(12'h008, 32'hFFFF, 32'h0);
        wr(12'h000, 32'h801);
        fill(9);
        rd(12'h008, 32'hFFFF, 32'h800);
        rd(12'h00C, 32'h4, 32'h4);
        run(8'h7, 8'h0);
        ck_irq(1'b1);
        wr(12'h000, 32'h103);
        wr(12'h010, 32'h2);
        rd(12'h00C, 32'h3F, 32'h1);
        wr(12'h004, 32'h301);
        run(8'h7, 8'h2);
        ck_irq(1'b0);
        run(8'h7, 8'h3);
        ck_irq(1'b1);
        rd(12'h008, 32'hFFFF, 32'h3);
        rd(12'h018, 32'hFF, 32'hA0);
        wr(12'h004, 32'h303);
        rd(12'h008, 32'hF, 32'h0);
        run(8'h7, 8'h5);
        wr(12'h004, 32'h300);
        rd(12'h008, 32'hF, 32'h0);
        run(8'h7, 8'h7);
        {rst, tmax, pmax} <= 17'h10000;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(12'h000, 32'hFFFF, 32'h100);
        rd(12'h008, 32'hFFFF, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
